// *** design/rcs_params.svh ***
// timing counts, offsets and field positions of the reset and clock supervisor
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
`define RCS_CLK_NS          20
`define RCS_PIN_LOW_PER     4'h8
`define RCS_EXTRA_PER       4'h7
`define RCS_STARTUP_NS      64000000
`define RCS_STARTUP_CYC     ((`RCS_STARTUP_NS) / `RCS_CLK_NS)
`define RCS_PF_NS           50
`define RCS_PF_CYC          (((`RCS_PF_NS) + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_CANCEL40_NS     40
`define RCS_CANCEL40_CYC    ((`RCS_CANCEL40_NS) / `RCS_CLK_NS)
`define RCS_CANCEL80_NS     80
`define RCS_CANCEL80_CYC    ((`RCS_CANCEL80_NS) / `RCS_CLK_NS)
`define RCS_IOSC_HALF_NS    125
`define RCS_IOSC_HALF_CYC   ((`RCS_IOSC_HALF_NS) / `RCS_CLK_NS)
`define RCS_IDLE_NS         2000
`define RCS_IDLE_CYC        ((`RCS_IDLE_NS) / `RCS_CLK_NS)
`define RCS_NOISE_REJ       4'h8
`define RCS_RECOVER_EDGES   4'h8
`define RCS_USER_LO         16'hc000
`define RCS_ADDR_PFCFG      4'h0
`define RCS_ADDR_STATUS     4'h1
`define RCS_PFCFG_DIS_BIT   0
`define RCS_PFCFG_SEL_BIT   1
`define RCS_ST_PIN_BIT      0
`define RCS_ST_AF_BIT       1
`define RCS_ST_PF_BIT       2
`define RCS_ST_INT_BIT      3
`define RCS_ST_FAIL_BIT     4
`define RCS_PFCFG_RST       1'h0
`endif

// *** design/rcs_pkg.sv ***
// types shared by the reset and clock supervisor modules
package rcs_pkg;
  typedef enum logic [1:0] {
    RCS_HOLD  = 2'b00,
    RCS_START = 2'b01,
    RCS_EXTRA = 2'b10,
    RCS_RUN   = 2'b11
  } rcs_rst_e;

  typedef struct packed {
    logic       lvl;
    logic [2:0] cnt;
    logic       rise;
    logic       rej;
  } rcs_filt_s;

  typedef struct packed {
    logic sel_int;
    logic out;
  } rcs_sw_s;
endpackage

// *** design/rcs_noise_filter.sv ***
// oscillator input noise canceller
`timescale 1ns/1ns
`default_nettype none
`include "rcs_params.svh"
module rcs_noise_filter import rcs_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic xin_i,
  input  wire logic wide_i,
  output logic      filt_o,
  output logic      rise_o,
  output logic      rej_o
);
  rcs_filt_s  st_ff;
  rcs_filt_s  nxt_st;
  logic [2:0] width;

  always_comb begin
    width = wide_i ? 3'(`RCS_CANCEL80_CYC) : 3'(`RCS_CANCEL40_CYC);
    nxt_st = st_ff;
    nxt_st.rise = 1'b0;
    nxt_st.rej = 1'b0;
    if (xin_i != st_ff.lvl) begin
      // level accepted only once stable for the cancel width
      if (st_ff.cnt + 3'h1 >= width) begin
        nxt_st.lvl = xin_i;
        nxt_st.cnt = 3'h0;
        nxt_st.rise = xin_i;
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end else if (st_ff.cnt != 3'h0) begin
      // glitch dropped, held level keeps the clock regular
      nxt_st.cnt = 3'h0;
      nxt_st.rej = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign filt_o = st_ff.lvl;
  assign rise_o = st_ff.rise;
  assign rej_o = st_ff.rej;

  short_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!wide_i && xin_i && !st_ff.lvl && st_ff.cnt == 3'h0) ##1 !xin_i |=> !st_ff.lvl)
    else $error("single cycle pulse passed the noise canceller");
endmodule // rcs_noise_filter
`default_nettype wire

// *** design/rcs_clk_switch.sv ***
// glitch-free changeover between external and internal clock levels
`timescale 1ns/1ns
`default_nettype none
module rcs_clk_switch import rcs_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ext_lvl_i,
  input  wire logic int_lvl_i,
  input  wire logic want_int_i,
  output logic      sys_clk_o,
  output logic      sel_int_o
);
  rcs_sw_s st_ff;
  rcs_sw_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // change source only with output and new source both low
    if (want_int_i != st_ff.sel_int && !st_ff.out &&
        !(want_int_i ? int_lvl_i : ext_lvl_i)) begin
      nxt_st.sel_int = want_int_i;
    end
    nxt_st.out = nxt_st.sel_int ? int_lvl_i : ext_lvl_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sys_clk_o = st_ff.out;
  assign sel_int_o = st_ff.sel_int;

  switch_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(st_ff.sel_int) |-> !st_ff.out && !$past(st_ff.out))
    else $error("clock source changed while system clock high");
endmodule // rcs_clk_switch
`default_nettype wire

// *** design/rcs_supervisor.sv ***
// reset sequencing, address and power fail resets, oscillator noise protector
`timescale 1ns/1ns
`default_nettype none
`include "rcs_params.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - reset pin low for 8 oscillator periods is a valid reset
// - after release wait 64 ms then 7 oscillator periods before running
// - resets never touch data RAM; only the cpu reset line moves
// - start-up timer begins only once the reset pin is high again
// - fetch below c000 raises an internal system reset
// - power-fail detection enabled while the disable bit is clear
// - low supply held over 50 ns resets cpu when select bit set
// - noise canceller holds the clock level through glitches
// - persistent high-frequency noise moves clock to internal oscillator
// - halted, shorted, open or slow oscillator moves clock to internal
// - clock returns to external once its edges are normal again
// - 40 ns width drops clock activity faster than 12.5 MHz
// - 80 ns width drops clock activity faster than 6.25 MHz
// - internal clock option drives oscillator output with clock divided by 4
// - internal clock option runs from internal oscillator only while the protector is on
// - protector off disables canceller, changeover and internal oscillator
// - changeover off never switches the clock source on failure
module rcs_supervisor import rcs_pkg::*; #(
  parameter int unsigned STARTUP_CYC = `RCS_STARTUP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        rst_pin_n_i,
  input  wire logic        xin_i,
  input  wire logic        lvd_i,
  input  wire logic        fetch_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic        osc_noise_protector_i,
  input  wire logic        osc_fail_changeover_i,
  input  wire logic        noise_cancel_width_option_i,
  input  wire logic        int_clk_option_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o,
  output logic             cpu_rst_n_o,
  output logic             sys_clk_o,
  output logic             clk_int_o,
  output logic             osc_output_pin_o
);
  typedef struct packed {
    rcs_rst_e    rst_st;
    logic [23:0] tmr;
    logic [3:0]  low_cnt;
    logic [3:0]  ext_cnt;
    logic [2:0]  pf_cnt;
    logic        pf_dis;
    logic        pf_sel;
    logic        pf_flag;
    logic        af_flag;
    logic        pin_flag;
    logic        opt_onp;
    logic        opt_ofp;
    logic        opt_w80;
    logic        opt_inclk;
    logic [3:0]  io_cnt;
    logic        io_clk;
    logic [1:0]  div4;
    logic        osc_output_pin;
    logic [6:0]  idle;
    logic [3:0]  rej_cnt;
    logic [3:0]  good_cnt;
    logic        osc_fail;
    logic        cpu_rst_n;
    logic [7:0]  rdata;
    logic        sys_prev;
  } rcs_sup_s;

  rcs_sup_s st_ff;
  rcs_sup_s nxt_st;
  logic     filt;
  logic     filt_rise;
  logic     filt_rej;
  logic     ext_lvl;
  logic     want_int;
  logic     sys_clk;
  logic     sel_int;
  logic     sys_rise;
  logic     io_rise;
  logic     pf_hit;
  logic     af_hit;
  logic     pin_hit;
  logic     st_wr;

  function automatic logic [3:0] sat_inc4(input logic [3:0] v, input logic [3:0] lim);
    sat_inc4 = (v >= lim) ? lim : v + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  rcs_noise_filter u_filt (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .xin_i  (xin_i),
    .wide_i (st_ff.opt_w80),
    .filt_o (filt),
    .rise_o (filt_rise),
    .rej_o  (filt_rej)
  );

  rcs_clk_switch u_sw (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .ext_lvl_i  (ext_lvl),
    .int_lvl_i  (st_ff.io_clk),
    .want_int_i (want_int),
    .sys_clk_o  (sys_clk),
    .sel_int_o  (sel_int)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // protector off: raw oscillator, no changeover
    ext_lvl = st_ff.opt_onp ? filt : xin_i;
    want_int = st_ff.opt_onp &&
               (st_ff.opt_inclk || (st_ff.opt_ofp && st_ff.osc_fail));
    sys_rise = sys_clk && !st_ff.sys_prev;
    st_wr = we_i && addr_i == `RCS_ADDR_STATUS;
    pin_hit = !rst_pin_n_i && sys_rise && st_ff.low_cnt == `RCS_PIN_LOW_PER - 4'h1;
    pf_hit = !st_ff.pf_dis && lvd_i && st_ff.pf_cnt == 3'(`RCS_PF_CYC - 1);
    af_hit = st_ff.rst_st == RCS_RUN && fetch_i && fetch_addr_i < `RCS_USER_LO;
    io_rise = st_ff.opt_onp && !st_ff.io_clk &&
              st_ff.io_cnt == 4'(`RCS_IOSC_HALF_CYC - 1);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sys_prev = sys_clk;
    // options are straps, followed only while held in reset
    if (st_ff.rst_st == RCS_HOLD) begin
      nxt_st.opt_onp = osc_noise_protector_i;
      nxt_st.opt_ofp = osc_fail_changeover_i;
      nxt_st.opt_w80 = noise_cancel_width_option_i;
      nxt_st.opt_inclk = int_clk_option_i;
    end
    // pin low time in oscillator periods
    if (rst_pin_n_i) begin
      nxt_st.low_cnt = 4'h0;
    end else if (sys_rise) begin
      nxt_st.low_cnt = sat_inc4(st_ff.low_cnt, `RCS_PIN_LOW_PER);
    end
    // supply detector must stay high for the filter time
    if (!lvd_i || st_ff.pf_dis) begin
      nxt_st.pf_cnt = 3'h0;
    end else if (st_ff.pf_cnt != 3'(`RCS_PF_CYC - 1)) begin
      nxt_st.pf_cnt = st_ff.pf_cnt + 3'h1;
    end
    // reset sequencer
    case (st_ff.rst_st)
      RCS_HOLD: begin
        nxt_st.cpu_rst_n = 1'b0;
        nxt_st.tmr = 24'h0;
        if (rst_pin_n_i) begin
          nxt_st.rst_st = RCS_START;
        end
      end
      RCS_START: begin
        if (st_ff.tmr == 24'(STARTUP_CYC - 1)) begin
          nxt_st.rst_st = RCS_EXTRA;
          nxt_st.ext_cnt = 4'h0;
        end else begin
          nxt_st.tmr = st_ff.tmr + 24'h1;
        end
      end
      RCS_EXTRA: begin
        if (sys_rise) begin
          nxt_st.ext_cnt = st_ff.ext_cnt + 4'h1;
          if (st_ff.ext_cnt == `RCS_EXTRA_PER - 4'h1) begin
            nxt_st.rst_st = RCS_RUN;
            nxt_st.cpu_rst_n = 1'b1;
          end
        end
      end
      RCS_RUN: begin
        nxt_st.cpu_rst_n = 1'b1;
      end
      default: begin
        nxt_st.rst_st = RCS_HOLD;
      end
    endcase
    // only the cpu reset line is driven, data RAM has no reset path
    if (pin_hit || af_hit || (pf_hit && st_ff.pf_sel)) begin
      nxt_st.rst_st = RCS_HOLD;
      nxt_st.cpu_rst_n = 1'b0;
    end
    // sticky causes, a new event wins over the clear
    if (st_wr && wdata_i[`RCS_ST_PIN_BIT]) nxt_st.pin_flag = 1'b0;
    if (st_wr && wdata_i[`RCS_ST_AF_BIT]) nxt_st.af_flag = 1'b0;
    if (st_wr && wdata_i[`RCS_ST_PF_BIT]) nxt_st.pf_flag = 1'b0;
    if (pin_hit) nxt_st.pin_flag = 1'b1;
    if (af_hit) nxt_st.af_flag = 1'b1;
    if (pf_hit) nxt_st.pf_flag = 1'b1;
    // internal oscillator, stopped with the protector off
    if (!st_ff.opt_onp) begin
      nxt_st.io_cnt = 4'h0;
      nxt_st.io_clk = 1'b0;
      nxt_st.div4 = 2'h0;
    end else if (st_ff.io_cnt == 4'(`RCS_IOSC_HALF_CYC - 1)) begin
      nxt_st.io_cnt = 4'h0;
      nxt_st.io_clk = !st_ff.io_clk;
    end else begin
      nxt_st.io_cnt = st_ff.io_cnt + 4'h1;
    end
    if (io_rise) begin
      nxt_st.div4 = st_ff.div4 + 2'h1;
    end
    nxt_st.osc_output_pin = st_ff.opt_onp && st_ff.opt_inclk && st_ff.div4[1];
    // oscillator watch: idle time and rejected glitches
    if (!st_ff.opt_onp || !st_ff.opt_ofp) begin
      nxt_st.idle = 7'h0;
      nxt_st.rej_cnt = 4'h0;
      nxt_st.good_cnt = 4'h0;
      nxt_st.osc_fail = 1'b0;
    end else begin
      if (filt_rise) begin
        nxt_st.idle = 7'h0;
        nxt_st.rej_cnt = 4'h0;
      end else if (st_ff.idle != 7'(`RCS_IDLE_CYC - 1)) begin
        nxt_st.idle = st_ff.idle + 7'h1;
      end
      if (filt_rej && !filt_rise) begin
        nxt_st.rej_cnt = sat_inc4(st_ff.rej_cnt, `RCS_NOISE_REJ);
      end
      if (!st_ff.osc_fail) begin
        if (st_ff.idle == 7'(`RCS_IDLE_CYC - 1) ||
            st_ff.rej_cnt == `RCS_NOISE_REJ) begin
          nxt_st.osc_fail = 1'b1;
          nxt_st.good_cnt = 4'h0;
        end
      end else if (filt_rej || st_ff.idle == 7'(`RCS_IDLE_CYC - 1)) begin
        nxt_st.good_cnt = 4'h0;
      end else if (filt_rise) begin
        nxt_st.good_cnt = st_ff.good_cnt + 4'h1;
        if (st_ff.good_cnt == `RCS_RECOVER_EDGES - 4'h1) begin
          nxt_st.osc_fail = 1'b0;
          nxt_st.idle = 7'h0;
        end
      end
    end
    // register port
    if (we_i && addr_i == `RCS_ADDR_PFCFG) begin
      nxt_st.pf_dis = wdata_i[`RCS_PFCFG_DIS_BIT];
      nxt_st.pf_sel = wdata_i[`RCS_PFCFG_SEL_BIT];
    end
    nxt_st.rdata = 8'h00;
    if (re_i && addr_i == `RCS_ADDR_PFCFG) begin
      nxt_st.rdata[`RCS_PFCFG_DIS_BIT] = st_ff.pf_dis;
      nxt_st.rdata[`RCS_PFCFG_SEL_BIT] = st_ff.pf_sel;
    end else if (re_i && addr_i == `RCS_ADDR_STATUS) begin
      nxt_st.rdata[`RCS_ST_PIN_BIT] = st_ff.pin_flag;
      nxt_st.rdata[`RCS_ST_AF_BIT] = st_ff.af_flag;
      nxt_st.rdata[`RCS_ST_PF_BIT] = st_ff.pf_flag;
      nxt_st.rdata[`RCS_ST_INT_BIT] = sel_int;
      nxt_st.rdata[`RCS_ST_FAIL_BIT] = st_ff.osc_fail;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.rst_st <= RCS_HOLD;
      st_ff.pf_dis <= `RCS_PFCFG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign cpu_rst_n_o = st_ff.cpu_rst_n;
  assign sys_clk_o = sys_clk;
  assign clk_int_o = sel_int;
  assign osc_output_pin_o = st_ff.osc_output_pin;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  pin_low_hold_a: assert property (
    (st_ff.rst_st == RCS_HOLD && !rst_pin_n_i) |=> st_ff.rst_st == RCS_HOLD)
    else $error("left reset while pin still low");
  pin_valid_a: assert property (
    pin_hit |=> !cpu_rst_n_o && st_ff.pin_flag)
    else $error("valid pin reset not taken");
  startup_end_a: assert property (
    (st_ff.rst_st == RCS_START && st_ff.tmr == 24'(STARTUP_CYC - 1)) |=>
      st_ff.rst_st == RCS_EXTRA && !cpu_rst_n_o)
    else $error("start-up interval end wrong");
  run_entry_a: assert property (
    $rose(cpu_rst_n_o) |-> $past(st_ff.rst_st) == RCS_EXTRA && $past(sys_rise))
    else $error("cpu released outside extra periods");
  addr_fail_a: assert property (
    (st_ff.rst_st == RCS_RUN && fetch_i && fetch_addr_i < 16'hc000) |=>
      !cpu_rst_n_o ##1 st_ff.af_flag)
    else $error("address fail reset missing");
  pf_reset_a: assert property (
    (!st_ff.pf_dis && st_ff.pf_sel && lvd_i)[*3] |=> !cpu_rst_n_o)
    else $error("power fail reset missing");
  pf_disabled_a: assert property (
    st_ff.pf_dis |=> !$rose(st_ff.pf_flag))
    else $error("power fail flagged while disabled");
  osc_output_pin_div_a: assert property (
    (st_ff.opt_onp && st_ff.opt_inclk && $changed(st_ff.div4)) |->
      $past(io_rise))
    else $error("oscillator output not from internal clock");
  onp_off_a: assert property (
    !st_ff.opt_onp |=> !st_ff.io_clk && !clk_int_o && !st_ff.osc_fail)
    else $error("protector parts active while disabled");
  ofp_off_a: assert property (
    (!st_ff.opt_ofp && !st_ff.opt_inclk) |=> !st_ff.osc_fail)
    else $error("changeover active while disabled");
  idle_fail_a: assert property (
    (st_ff.opt_onp && st_ff.opt_ofp && !st_ff.osc_fail &&
     st_ff.idle == 7'(`RCS_IDLE_CYC - 1)) |=> st_ff.osc_fail)
    else $error("halted oscillator not detected");

  run_reached_c: cover property ($rose(cpu_rst_n_o));
  fail_over_c: cover property ($rose(st_ff.osc_fail) ##[1:1000] $rose(clk_int_o));
  recover_c: cover property ($fell(st_ff.osc_fail));
  addr_fail_c: cover property (af_hit);
endmodule // rcs_supervisor
`default_nettype wire

// *** dv/rcs_osc_model.sv ***
// model of the external reset circuit and crystal oscillator
`timescale 1ns/1ns
`default_nettype none
module rcs_osc_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  output logic            xin_o,
  output logic            rst_pin_n_o
);
  logic [3:0] ph_ff;

  initial begin
    xin_o       = 1'b0;
    ph_ff       = 4'h0;
    rst_pin_n_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode 0 runs at 240 ns, 1 halts, 2 sends 20 ns glitches, 3 sends 60 ns pulses
  always @(posedge clk_i) begin
    ph_ff <= (ph_ff == 4'hb) ? 4'h0 : ph_ff + 4'h1;
    case (mode_i)
      2'h0: xin_o <= (ph_ff < 4'h6);
      2'h1: xin_o <= 1'b0;
      2'h2: xin_o <= (ph_ff[1:0] == 2'h0);
      default: xin_o <= (ph_ff < 4'h3);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin held low over n oscillator rises, released before the next one
  task automatic hold_pin(input int n);
    // start low well after a rise so no earlier rise is counted
    @(posedge xin_o);
    repeat (6) @(posedge clk_i);
    rst_pin_n_o <= 1'b0;
    repeat (n) @(posedge xin_o);
    repeat (8) @(posedge clk_i);
    rst_pin_n_o <= 1'b1;
  endtask
endmodule // rcs_osc_model
`default_nettype wire

// *** dv/rcs_supervisor_test.sv ***
// self-checking bench for the reset and clock supervisor
`timescale 1ns/1ns
`default_nettype none
`include "rcs_params.svh"
module rcs_supervisor_test import rcs_pkg::*;;
  localparam int unsigned SU = 50;
  logic        clk_i, rstn_i, lvd_i, fetch_i, we_i, re_i;
  logic        prot_i, chg_i, wide_i, intc_i, xin, pin_n;
  logic        cpu_rst_n_o, sys_clk_o, clk_int_o, osc_output_pin_o;
  logic [15:0] fetch_addr_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic [1:0]  mode;
  int          err_total, total_checks, n;

  rcs_supervisor #(.STARTUP_CYC(SU)) rcs_supervisor_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .rst_pin_n_i(pin_n), .xin_i(xin), .lvd_i(lvd_i),
    .fetch_i(fetch_i), .fetch_addr_i(fetch_addr_i), .osc_noise_protector_i(prot_i),
    .osc_fail_changeover_i(chg_i), .noise_cancel_width_option_i(wide_i),
    .int_clk_option_i(intc_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .cpu_rst_n_o(cpu_rst_n_o), .sys_clk_o(sys_clk_o),
    .clk_int_o(clk_int_o), .osc_output_pin_o(osc_output_pin_o));

  rcs_osc_model rcs_osc_model_inst (
    .clk_i(clk_i), .mode_i(mode), .xin_o(xin), .rst_pin_n_o(pin_n));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? cpu_rst_n_o : (w == 1) ? clk_int_o : osc_output_pin_o;
  endfunction

  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic boot(input logic [3:0] opt);
    @(posedge clk_i);
    {prot_i, chg_i, wide_i, intc_i} <= opt;
    rstn_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    wait_lvl(0, 1'b1, 1000);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    check({8'h00, rdata_o & m}, {8'h00, e});
  endtask

  task automatic fetch(input logic [15:0] a);
    @(posedge clk_i);
    fetch_addr_i <= a;
    fetch_i      <= 1'b1;
    @(posedge clk_i);
    fetch_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic low_supply(input int c);
    @(posedge clk_i);
    lvd_i <= 1'b1;
    repeat (c) @(posedge clk_i);
    lvd_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic run_mode(input logic [1:0] m, input int w, input logic v, input int lim);
    @(posedge clk_i);
    mode <= m;
    wait_lvl(w, v, lim);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd(`RCS_ADDR_PFCFG, 8'hff, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'hff, 8'h00);
    rd(`RCS_ADDR_PFCFG, 8'hff, 8'h00);
  endtask

  task automatic t_pin;
    rcs_osc_model_inst.hold_pin(7);
    repeat (4) @(negedge clk_i);
    check(cpu_rst_n_o, 1'b1);
    rcs_osc_model_inst.hold_pin(8);
    @(negedge clk_i);
    check(cpu_rst_n_o, 1'b0);
    wait_lvl(0, 1'b1, 1000);
    check(n >= SU + 72 && n <= SU + 106, 1'b1);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_PIN_BIT, 8'h01 << `RCS_ST_PIN_BIT);
    wr(`RCS_ADDR_STATUS, 8'hff);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_PIN_BIT, 8'h00);
  endtask

  task automatic t_addr;
    fetch(16'hc000);
    check(cpu_rst_n_o, 1'b1);
    fetch(16'hbfff);
    check(cpu_rst_n_o, 1'b0);
    wait_lvl(0, 1'b1, 1000);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_AF_BIT, 8'h01 << `RCS_ST_AF_BIT);
    wr(`RCS_ADDR_STATUS, 8'hff);
  endtask

  task automatic t_pf;
    wr(`RCS_ADDR_PFCFG, 8'h02);
    low_supply(2);
    check(cpu_rst_n_o, 1'b1);
    low_supply(3);
    check(cpu_rst_n_o, 1'b0);
    wait_lvl(0, 1'b1, 1000);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_PF_BIT, 8'h01 << `RCS_ST_PF_BIT);
    wr(`RCS_ADDR_STATUS, 8'hff);
    wr(`RCS_ADDR_PFCFG, 8'h03);
    low_supply(6);
    check(cpu_rst_n_o, 1'b1);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_PF_BIT, 8'h00);
  endtask

  task automatic t_fail;
    run_mode(2'h1, 1, 1'b1, 200);
    check(clk_int_o, 1'b1);
    rd(`RCS_ADDR_STATUS, 8'h01 << `RCS_ST_INT_BIT, 8'h01 << `RCS_ST_INT_BIT);
    run_mode(2'h0, 1, 1'b0, 200);
    check(clk_int_o, 1'b0);
    run_mode(2'h2, 1, 1'b1, 200);
    check(clk_int_o, 1'b1);
    run_mode(2'h0, 1, 1'b0, 200);
    run_mode(2'h3, 1, 1'b1, 300);
    check(clk_int_o, 1'b0);
    run_mode(2'h0, 1, 1'b1, 1);
    boot(4'b1110);
    run_mode(2'h3, 1, 1'b1, 300);
    check(clk_int_o, 1'b1);
    run_mode(2'h0, 1, 1'b0, 200);
  endtask

  task automatic t_opts;
    boot(4'b1000);
    run_mode(2'h1, 1, 1'b1, 300);
    check(clk_int_o, 1'b0);
    run_mode(2'h0, 1, 1'b1, 1);
    boot(4'b0001);
    wait_lvl(2, 1'b1, 100);
    check({clk_int_o, osc_output_pin_o}, 2'b00);
    @(posedge clk_i);
    mode <= 2'h1;
    boot(4'b1001);
    check(clk_int_o, 1'b1);
    wait_lvl(2, 1'b0, 200);
    wait_lvl(2, 1'b1, 200);
    wait_lvl(2, 1'b0, 200);
    check(n[15:0], 16'h0018);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    {rstn_i, lvd_i, fetch_i, we_i, re_i} = 5'h00;
    {prot_i, chg_i, wide_i, intc_i} = 4'hc;
    fetch_addr_i = 16'hc000;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    mode = 2'h0;
    err_total = 0;
    total_checks = 0;
    boot(4'b1100);
    check(n >= SU + 72 && n <= SU + 106, 1'b1);
    t_regs();
    t_pin();
    t_addr();
    t_pf();
    t_fail();
    t_opts();
    close_out();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule // rcs_supervisor_test
`default_nettype wire
